//--- core/ptmr_pkg.sv
// ptmr_pkg: shared constants and types for the periodic timer block
// assumes a 32-bit axi4-lite register bus and a single 10 MHz clock
package ptmr_pkg;

  // ==========================================================
  // register map (printed offsets are register indexes)
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_TIMER_COUNT = 8'h11;
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h12;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_TIMER_PERIOD = 8'h92;
  localparam int ADDR_W = 12;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_TIMER_COUNT = 8'h00;
  localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLES = 8'h00;
  localparam logic [7:0] RST_TIMER_PERIOD = 8'hff;

  // ==========================================================
  // field positions
  localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
  localparam int BIT_PERIPHERAL_IRQ_GATE = 6;
  localparam int BIT_TIMER_MATCH_FLAG = 1;
  localparam int BIT_TIMER_RUN = 2;
  localparam int POS_POSTSCALE_SEL = 3;
  localparam int POS_PRESCALE_SEL = 0;
  localparam logic [7:0] MASK_TIMER_CONTROL = 8'h7f;

  // ==========================================================
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // timing: one instruction cycle is four clocks
  localparam int CLK_NS = 100;
  localparam int INSTR_NS = 400;
  localparam int INSTR_CYCLES = INSTR_NS / CLK_NS;

  typedef struct packed {
    logic [3:0] postscale;
    logic run;
    logic [1:0] prescale;
  } ptmr_ctrl_s;

  typedef struct packed {
    logic match;
    logic flag_set;
  } ptmr_evt_s;

endpackage : ptmr_pkg

//--- core/ptmr_regs.sv
// ptmr_regs: small register file, eight-bit words, registered read data
// assumes index decode is done by the caller
`timescale 1ns/100ps
module ptmr_regs
  import ptmr_pkg::*;
#(
  parameter int DEPTH = 4
)(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // write port
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [7:0] wdata,
  // read port
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];

  if (DEPTH < 2)
  begin : g_bad_depth
    $error("ptmr_regs: depth too small");
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_word
      always_ff @(posedge clk)
      begin
        if (!rstn)
          mem[gi] <= 8'h00;
        else if (we && waddr == gi)
          mem[gi] <= wdata;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rstn)
      rdata <= 8'h00;
    else
      rdata <= mem[raddr];
  end

endmodule : ptmr_regs

//--- core/ptmr_timer.sv
// ptmr_timer: 8-bit periodic timer with prescaler and postscaler, axi4-lite slave
// assumes an axi4-lite master on the same clock and synchronous active-low reset
//
// Notes on behaviour
// R1: a write to the count register clears both scaler counters.
// R2: a write to the control register clears both scaler counters.
// R3: every device reset source clears both scaler counters.
// R4: a write to the control register leaves the count unchanged, unless a prescaled tick in the same cycle still steps it.
// R5: the match pulse before the postscaler goes out to the serial port.
// R6: no peripheral interrupt leaves the block unless the peripheral gate bit is set.
// R7: when running, the count steps per prescaled tick, wraps at the period and feeds the postscaler.
`timescale 1ns/100ps
module ptmr_timer
  import ptmr_pkg::*;
#(
  parameter int SCRATCH_DEPTH = 4
)(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // additional device reset sources, active high pulses
  input wire logic brown_out_reset,
  input wire logic external_master_clear,
  input wire logic watchdog_reset,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial port shift clock source and interrupt
  output logic timer_match_out,
  output logic irq
);

  if (SCRATCH_DEPTH < 2)
  begin : g_bad_depth
    $error("ptmr_timer: scratch depth too small");
  end

  // ==========================================================
  // register state
  logic [7:0] interrupt_control;
  logic [7:0] peripheral_irq_flags;
  logic [7:0] peripheral_irq_enables;
  logic [7:0] timer_count;
  logic [7:0] timer_period;
  ptmr_ctrl_s timer_control;
  ptmr_evt_s evt;
  logic any_reset;
  assign any_reset = !rstn || brown_out_reset || external_master_clear || watchdog_reset;

  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[9:2];
  endfunction : word_index

  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == IDX_INTERRUPT_CONTROL) || (i == IDX_PERIPHERAL_IRQ_FLAGS) ||
                (i == IDX_TIMER_COUNT) || (i == IDX_TIMER_CONTROL) ||
                (i == IDX_PERIPHERAL_IRQ_ENABLES) || (i == IDX_TIMER_PERIOD);
  endfunction : is_mapped

  // ==========================================================
  // axi write channel: take address and data in either order
  logic aw_held;
  logic w_held;
  logic [7:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [7:0] wr_byte;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_byte = w_data[7:0];

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_idx <= word_index(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_en;
  assign wr_en = wr_fire && w_strb[0];
  logic wr_count;
  logic wr_ctrl;
  assign wr_count = wr_en && aw_idx == IDX_TIMER_COUNT;
  assign wr_ctrl = wr_en && aw_idx == IDX_TIMER_CONTROL;

  // ==========================================================
  // prescaler and postscaler
  logic [3:0] pre_cnt;
  logic [3:0] post_cnt;
  logic [1:0] instr_div;
  logic instr_tick;
  logic pre_tick;
  logic [3:0] pre_limit;
  logic period_hit;
  assign instr_tick = instr_div == 2'(INSTR_CYCLES - 1);

  always_comb
  begin
    unique case (timer_control.prescale)
      2'h0: pre_limit = 4'h0;
      2'h1: pre_limit = 4'h3;
      default: pre_limit = 4'hf;
    endcase
  end
  assign pre_tick = instr_tick && timer_control.run && pre_cnt == pre_limit;
  assign period_hit = pre_tick && timer_count == timer_period;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      instr_div <= 2'h0;
    else
      instr_div <= instr_tick ? 2'h0 : instr_div + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (any_reset || wr_count || wr_ctrl) // R1 R2 R3
    begin
      pre_cnt <= 4'h0;
      post_cnt <= 4'h0;
    end
    else if (instr_tick && timer_control.run)
    begin
      pre_cnt <= (pre_cnt == pre_limit) ? 4'h0 : pre_cnt + 4'h1;
      if (period_hit) // R7
        post_cnt <= (post_cnt == timer_control.postscale) ? 4'h0 : post_cnt + 4'h1;
    end
  end

  // ==========================================================
  // timer count and control
  always_ff @(posedge clk)
  begin
    if (!rstn)
      timer_count <= RST_TIMER_COUNT;
    else if (wr_count)
      timer_count <= wr_byte;
    else if (pre_tick) // R7
      timer_count <= period_hit ? 8'h00 : timer_count + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      timer_control <= ptmr_ctrl_s'(RST_TIMER_CONTROL[6:0]);
      timer_period <= RST_TIMER_PERIOD;
      interrupt_control <= RST_INTERRUPT_CONTROL;
      peripheral_irq_enables <= RST_PERIPHERAL_IRQ_ENABLES;
    end
    else if (wr_en)
    begin
      if (aw_idx == IDX_TIMER_CONTROL)
        timer_control <= ptmr_ctrl_s'(wr_byte[6:0]); // R4
      if (aw_idx == IDX_TIMER_PERIOD)
        timer_period <= wr_byte;
      if (aw_idx == IDX_INTERRUPT_CONTROL)
        interrupt_control <= wr_byte;
      if (aw_idx == IDX_PERIPHERAL_IRQ_ENABLES)
        peripheral_irq_enables <= wr_byte;
    end
  end

  // ==========================================================
  // events, sticky flags and interrupt
  assign evt = '{match: period_hit,
                 flag_set: period_hit && post_cnt == timer_control.postscale};
  assign timer_match_out = evt.match; // R5

  always_ff @(posedge clk)
  begin
    if (!rstn)
      peripheral_irq_flags <= RST_PERIPHERAL_IRQ_FLAGS;
    else
    begin
      if (wr_en && aw_idx == IDX_PERIPHERAL_IRQ_FLAGS)
        peripheral_irq_flags <= peripheral_irq_flags & ~wr_byte;
      if (evt.flag_set) // R7
        peripheral_irq_flags[BIT_TIMER_MATCH_FLAG] <= 1'b1;
    end
  end

  assign irq = interrupt_control[BIT_PERIPHERAL_IRQ_GATE] &&
               |(peripheral_irq_flags & peripheral_irq_enables); // R6

  // ==========================================================
  // axi read channel, data through the registered word store
  logic [7:0] rd_sel;
  logic [7:0] rd_byte;
  logic [1:0] rd_pending;
  logic [7:0] rd_idx;
  logic rd_take;
  assign s_axi_arready = !rd_pending[0] && !rd_pending[1] && !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    unique case (word_index(s_axi_araddr))
      IDX_INTERRUPT_CONTROL: rd_sel = interrupt_control;
      IDX_PERIPHERAL_IRQ_FLAGS: rd_sel = peripheral_irq_flags;
      IDX_TIMER_COUNT: rd_sel = timer_count;
      IDX_TIMER_CONTROL: rd_sel = {1'b0, timer_control} & MASK_TIMER_CONTROL;
      IDX_PERIPHERAL_IRQ_ENABLES: rd_sel = peripheral_irq_enables;
      IDX_TIMER_PERIOD: rd_sel = timer_period;
      default: rd_sel = 8'h00;
    endcase
  end

  // word is captured at the address handshake, so later counting does not tear the read
  ptmr_regs #(.DEPTH(SCRATCH_DEPTH)) u_store (.clk(clk), .rstn(rstn), .we(rd_take),
    .waddr('0), .wdata(rd_sel), .raddr('0), .rdata(rd_byte));

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rd_pending <= 2'h0;
      rd_idx <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      rd_pending <= {rd_pending[0], rd_take};
      if (rd_take)
        rd_idx <= word_index(s_axi_araddr);
      if (rd_pending[1])
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  chk_count_clears_scalers: assert property (@(posedge clk) disable iff (!rstn)
    wr_count |=> pre_cnt == 4'h0 && post_cnt == 4'h0) // R1
    else $error("scalers not cleared by count write");

  chk_ctrl_clears_scalers: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl |=> pre_cnt == 4'h0 && post_cnt == 4'h0) // R2
    else $error("scalers not cleared by control write");

  chk_resets_clear_scalers: assert property (@(posedge clk)
    (watchdog_reset || brown_out_reset || external_master_clear || !rstn)
      |=> pre_cnt == 4'h0 && post_cnt == 4'h0) // R3
    else $error("scalers not cleared by reset");

  chk_ctrl_keeps_count: assert property (@(posedge clk) disable iff (!rstn)
    (wr_ctrl && !pre_tick) |=> timer_count == $past(timer_count)) // R4
    else $error("control write disturbed count");

  chk_match_to_port: assert property (@(posedge clk) disable iff (!rstn)
    timer_match_out == (pre_tick && timer_count == timer_period)) // R5
    else $error("match output wrong");

  chk_gate_blocks_irq: assert property (@(posedge clk) disable iff (!rstn)
    !interrupt_control[BIT_PERIPHERAL_IRQ_GATE] |-> !irq) // R6
    else $error("irq leaked without peripheral gate");

  sequence s_flag_event;
    evt.flag_set && !(wr_en && aw_idx == IDX_TIMER_COUNT);
  endsequence

  chk_flag_on_rollover: assert property (@(posedge clk) disable iff (!rstn)
    s_flag_event |=> peripheral_irq_flags[BIT_TIMER_MATCH_FLAG]) // R7
    else $error("match flag not set on rollover");

  chk_wrap_to_zero: assert property (@(posedge clk) disable iff (!rstn)
    (period_hit && !wr_count) |=> timer_count == 8'h00) // R7
    else $error("count did not wrap at period");

endmodule : ptmr_timer

//--- test/ptmr_ssp_model.sv
// ptmr_serial_model: serial port side that takes the timer match pulse as shift clock source
// assumes one clock domain shared with the timer and a synchronous active-low reset
`timescale 1ns/100ps
module ptmr_serial_model
  import ptmr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // timer side
  input wire logic timer_match_out,
  // observations
  output logic shift_clk,
  output logic [15:0] last_gap,
  output logic wide_pulse
);
  logic [15:0] since;
  logic prev;

  // ==========================================================
  // shift clock toggles once per match, gap between matches is recorded
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      shift_clk <= 1'b0;
      since <= 16'h0000;
      last_gap <= 16'h0000;
      prev <= 1'b0;
      wide_pulse <= 1'b0;
    end
    else
    begin
      prev <= timer_match_out;
      since <= timer_match_out ? 16'h0001 : since + 16'h0001;
      if (timer_match_out)
      begin
        shift_clk <= ~shift_clk;
        last_gap <= since;
      end
      if (timer_match_out && prev)
        wide_pulse <= 1'b1;
    end
  end
endmodule : ptmr_serial_model

//--- test/testbench.sv
// testbench: register, scaler clearing, match output and interrupt checks for ptmr_timer
// assumes the timer answers over axi4-lite and a serial port model watches the match pulse
`timescale 1ns/100ps
module testbench
  import ptmr_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic brown_out = 1'b0, ext_clear = 1'b0, wd_reset = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, match, irq, sclk, wide;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] gap;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int err_count = 0;
  int checked = 0;
  int seed = 42741;
  logic [7:0] v, p;
  logic [7:0] idx_t[6] = '{IDX_INTERRUPT_CONTROL, IDX_PERIPHERAL_IRQ_FLAGS, IDX_TIMER_COUNT,
                           IDX_TIMER_CONTROL, IDX_PERIPHERAL_IRQ_ENABLES, IDX_TIMER_PERIOD};
  logic [7:0] rst_t[6] = '{RST_INTERRUPT_CONTROL, RST_PERIPHERAL_IRQ_FLAGS, RST_TIMER_COUNT,
                           RST_TIMER_CONTROL, RST_PERIPHERAL_IRQ_ENABLES, RST_TIMER_PERIOD};

  always #50 clk = ~clk;

  ptmr_timer uut (.clk(clk), .rstn(rstn), .brown_out_reset(brown_out),
    .external_master_clear(ext_clear), .watchdog_reset(wd_reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_match_out(match), .irq(irq));

  ptmr_serial_model port_model (.clk(clk), .rstn(rstn), .timer_match_out(match), .shift_clk(sclk),
    .last_gap(gap), .wide_pulse(wide));

  // ==========================================================
  // checking and reporting
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // results are compared against the oldest note as they appear
  always @(posedge clk)
  begin
    if (bvalid && bready)
      chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready)
      chk({rresp, rdata}, rq.pop_front());
  end

  // ==========================================================
  // bus tasks
  function automatic logic [ADDR_W-1:0] ra(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ra

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] r);
    logic awd, wd;
    awd = 1'b0;
    wd = 1'b0;
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(awd && wd))
    begin
      @(posedge clk);
      if (awvalid && awready && !awd)
      begin
        awd = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready && !wd)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid)
      @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] r);
    rq.push_back({r, 24'h0, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid)
      @(posedge clk);
    rready <= 1'b0;
  endtask : rd

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    foreach (idx_t[i])
      rd(ra(idx_t[i]), rst_t[i], RESP_OKAY);
    rd(12'h004, 8'h00, RESP_SLVERR);
    wr(12'h004, 8'hff, RESP_SLVERR);
    // a write without its low byte lane must leave the register alone
    wstrb <= 4'he;
    wr(ra(IDX_TIMER_PERIOD), 8'h00, RESP_OKAY);
    wstrb <= 4'hf;
    rd(ra(IDX_TIMER_PERIOD), RST_TIMER_PERIOD, RESP_OKAY);
    $display("test reset_map done");
    v = 8'($random(seed));
    wr(ra(IDX_TIMER_COUNT), v, RESP_OKAY);
    repeat (8)
    begin
      wr(ra(IDX_TIMER_CONTROL), 8'h06, RESP_OKAY);
      repeat (30) @(posedge clk);
    end
    rd(ra(IDX_TIMER_COUNT), v, RESP_OKAY);
    rd(ra(IDX_TIMER_CONTROL), 8'h06, RESP_OKAY);
    repeat (8)
    begin
      wr(ra(IDX_TIMER_COUNT), v, RESP_OKAY);
      repeat (30) @(posedge clk);
      rd(ra(IDX_TIMER_COUNT), v, RESP_OKAY);
    end
    for (int s = 0; s < 3; s++)
    begin
      repeat (8)
      begin
        @(posedge clk);
        brown_out <= (s == 0);
        ext_clear <= (s == 1);
        wd_reset <= (s == 2);
        @(posedge clk);
        {brown_out, ext_clear, wd_reset} <= 3'b000;
        repeat (40) @(posedge clk);
      end
      rd(ra(IDX_TIMER_COUNT), v, RESP_OKAY);
    end
    $display("test scaler_clear done");
    wr(ra(IDX_TIMER_CONTROL), 8'h00, RESP_OKAY);
    p = 8'h01 + (8'($random(seed)) & 8'h03);
    wr(ra(IDX_TIMER_PERIOD), p, RESP_OKAY);
    rd(ra(IDX_TIMER_PERIOD), p, RESP_OKAY);
    wr(ra(IDX_TIMER_COUNT), 8'h00, RESP_OKAY);
    wr(ra(IDX_PERIPHERAL_IRQ_ENABLES), 8'h02, RESP_OKAY);
    wr(ra(IDX_TIMER_CONTROL), 8'h04, RESP_OKAY);
    repeat (100) @(posedge clk);
    chk({18'h0, gap}, 34'((p + 1) * INSTR_CYCLES));
    chk({33'h0, wide}, 34'h0);
    // divide-by-four prescaler with a random postscale field
    v = 8'h05 | (8'($random(seed)) & 8'h78);
    wr(ra(IDX_TIMER_CONTROL), v, RESP_OKAY);
    rd(ra(IDX_TIMER_CONTROL), v, RESP_OKAY);
    repeat (200) @(posedge clk);
    chk({18'h0, gap}, 34'((p + 1) * INSTR_CYCLES * 4));
    chk({33'h0, irq}, 34'h0);
    rd(ra(IDX_PERIPHERAL_IRQ_FLAGS), 8'h02, RESP_OKAY);
    wr(ra(IDX_INTERRUPT_CONTROL), 8'h40, RESP_OKAY);
    @(posedge clk);
    chk({33'h0, irq}, 34'h1);
    wr(ra(IDX_PERIPHERAL_IRQ_ENABLES), 8'h00, RESP_OKAY);
    @(posedge clk);
    chk({33'h0, irq}, 34'h0);
    wr(ra(IDX_TIMER_CONTROL), 8'h00, RESP_OKAY);
    wr(ra(IDX_PERIPHERAL_IRQ_FLAGS), 8'h02, RESP_OKAY);
    wr(ra(IDX_PERIPHERAL_IRQ_ENABLES), 8'h02, RESP_OKAY);
    @(posedge clk);
    chk({33'h0, irq}, 34'h0);
    rd(ra(IDX_PERIPHERAL_IRQ_FLAGS), 8'h00, RESP_OKAY);
    $display("test match_irq done");
    repeat (4) @(posedge clk);
    final_report();
  end

  // ==========================================================
  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule : testbench
